// *** tcm_defs.svh ***
// Constants of the tape channel memory interface: offsets, fields, reset values
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH
// Register byte offsets on the Avalon slave
`define TCM_OFS_OUT5 5'h00
`define TCM_OFS_OUT6 5'h04
`define TCM_OFS_STAT0 5'h08
`define TCM_OFS_STAT1 5'h0C
`define TCM_OFS_STAT2 5'h10
// Own 4-bit connect code; arbitrary value
`define TCM_CONNECT_CODE 4'hA
// Output channel six fields (channel bit n sits at word bit 15-n)
`define TCM_C6_SA 15
`define TCM_C6_TA 14
`define TCM_C6_IF 13
`define TCM_C6_PCLR 12
`define TCM_C6_CHF 11
`define TCM_C6_CODE 3:0
// Output channel five fields
`define TCM_C5_CMP 15
`define TCM_C5_ADDR 14:0
`define TCM_C5_TABLE 14:8
`define TCM_C5_CONN 13
`define TCM_C5_DEVCODE 11:0
`define TCM_C5_UNIT 2:0
// Internal function bits
`define TCM_FN_CODED 15
`define TCM_FN_WRITE 14
`define TCM_FN_ODDEVEN 12
`define TCM_FN_NOMEM 11
`define TCM_FN_HALT 10
`define TCM_FN_BACK 9
// Address layout
`define TCM_PAGE 14:11
`define TCM_OFFS 10:0
`define TCM_OFFS_MAX 11'h7FF
// Reset values
`define TCM_RST_WORD 16'h0000
`define TCM_RST_ADDR 15'h0000
`endif

// *** tcm_pkg.sv ***
// Types shared by the tape channel memory interface
package tcm_pkg;
  typedef logic [14:0] tcm_addr_t;
  typedef enum {ST_IDLE, ST_RD_WAIT, ST_LOOKUP, ST_STORE, ST_FETCH, ST_SEND, ST_HOLD} tcm_state_e;
endpackage : tcm_pkg

// *** tcm_addr_if.sv ***
// Carrier between the transfer controller and the address generator
`timescale 1ns/1ps
`default_nettype none
interface tcm_addr_if;
  import tcm_pkg::*;
  logic load;
  tcm_addr_t start;
  logic page_load;
  logic [3:0] next_page;
  logic adv;
  logic dec;
  logic two;
  tcm_addr_t cur;
  logic page_pend;
  modport ctl (output load, start, page_load, next_page, adv, dec, two, input cur, page_pend);
  modport gen (input load, start, page_load, next_page, adv, dec, two, output cur, page_pend);
endinterface : tcm_addr_if
`default_nettype wire

// *** tcm_addr_gen.sv ***
// Current buffer memory address with page chaining
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defs.svh"
module tcm_addr_gen (
  input wire logic clk,
  input wire logic clr,
  tcm_addr_if.gen a
);
  import tcm_pkg::*;
  logic [11:0] offs_nxt;
  logic [3:0] page_r;
  logic pend_r;
  tcm_addr_t cur_r;

  // Offset step: one or two banks, forward or back; bit 11 flags a page crossing
  always_comb begin
    if (a.dec)
      offs_nxt = {1'b0, cur_r[`TCM_OFFS]} - (a.two ? 12'h002 : 12'h001);
    else
      offs_nxt = {1'b0, cur_r[`TCM_OFFS]} + (a.two ? 12'h002 : 12'h001);
  end

  ////////////////////////////////////////////////////////////////
  // Pending next page; a new one may arrive any time before the wrap
  always_ff @(posedge clk) begin
    if (clr)
      pend_r <= 1'b0;
    else if (a.page_load)
      pend_r <= a.next_page != cur_r[`TCM_PAGE]; // Same page means no chaining, so compare stays live
    else if (a.adv && offs_nxt[11])
      pend_r <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (clr)
      page_r <= 4'h0;
    else if (a.page_load)
      page_r <= a.next_page;
  end

  // Address advance after every word; on the wrap the page field takes the pending page, else steps by one
  always_ff @(posedge clk) begin
    if (clr)
      cur_r <= `TCM_RST_ADDR;
    else if (a.load)
      cur_r <= a.start;
    else if (a.adv) begin
      cur_r[`TCM_OFFS] <= offs_nxt[10:0];
      if (offs_nxt[11] && pend_r)
        cur_r[`TCM_PAGE] <= page_r;
      else if (offs_nxt[11])
        cur_r[`TCM_PAGE] <= a.dec ? cur_r[`TCM_PAGE] - 4'h1 : cur_r[`TCM_PAGE] + 4'h1;
    end
  end

  assign a.cur = cur_r;
  assign a.page_pend = pend_r;
endmodule : tcm_addr_gen
`default_nettype wire

// *** tcm_channel.sv ***
// Tape channel memory interface: channel registers, transfer control, tape port
// Notes on behaviour
// - Emulate 12-bit channel between tapes and memory
// - Address compare ends writes only
// - End of record ends a read
// - Memory, transmission and write parity errors
// - Memory parity only on write fetch
// - Parity stops transfer only when halt selected
// - Transfer follows supplied pages across boundaries
// - Control on out five/six, status in
// - Starting address sets transfer area start
// - Table address locates conversion table; table_r is never loaded and stays zero
// - Function bits start operation, set conditions
// - Connect code selects one of eight units
// - Master clear stops transfer, clears functions
// - Own unique 4-bit connect code selects us
// - Control and status only while connected
// - Connected while code held on channel six
// - Unit stays selected after disconnect
// - Three 16-bit status words
// - Strobe set then cleared captures word
// - Function bit 5 halts on parity; persists
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defs.svh"
module tcm_channel (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mem_req,
  output logic mem_we,
  output tcm_pkg::tcm_addr_t mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_perr,
  output logic [7:0] tape_sel,
  output logic [11:0] tape_code,
  output logic tape_conn_stb,
  output logic tape_func_stb,
  input wire logic tape_rdy,
  input wire logic [11:0] tape_din,
  input wire logic tape_din_par,
  output logic tape_ack,
  output logic [11:0] tape_dout,
  output logic tape_dout_par,
  output logic tape_dout_vld,
  input wire logic tape_take,
  input wire logic tape_eor,
  input wire logic tape_wperr,
  input wire logic [11:0] tape_status
);
  import tcm_pkg::*;

  tcm_addr_if ai ();
  tcm_state_e state_r;
  logic [15:0] out5_r;
  logic [15:0] out6_r;
  logic [15:0] func_r;
  logic [14:0] term_r;
  logic cmp_en_r;
  logic [6:0] table_r;
  logic [15:0] data_r;
  logic resp_r;
  logic go_r;
  logic done_r;
  logic eor_r;
  logic mperr_r;
  logic tperr_r;
  logic wperr_r;
  logic [15:0] wdata;
  logic [15:0] strobe;
  logic connected;
  logic clr;
  logic wr_now;
  logic rd_now;
  logic coded;
  logic is_write;
  logic halt;
  logic nomem;
  logic mem_gnt;
  logic last_word;
  logic rx_bad;
  logic [28:0] sy1_r;
  logic [28:0] sy2_r;
  logic rdy_s;
  logic take_s;
  logic eor_s;
  logic wperr_s;
  logic [11:0] din_s;
  logic dpar_s;
  logic [11:0] stat_s;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers; tape data is settled before its ready level
  always_ff @(posedge clk) begin
    sy1_r <= {tape_rdy, tape_take, tape_eor, tape_wperr, tape_din, tape_din_par, tape_status};
  end

  always_ff @(posedge clk) begin
    sy2_r <= sy1_r;
  end

  assign {rdy_s, take_s, eor_s, wperr_s, din_s, dpar_s, stat_s} = sy2_r;

  ////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access, then a one-cycle answer
  assign avs_waitrequest = (avs_read | avs_write) & ~resp_r;
  assign wr_now = avs_write & resp_r;
  assign rd_now = avs_read & ~resp_r;
  assign wdata = avs_writedata[15:0];

  always_ff @(posedge clk) begin
    if (sys_rst)
      resp_r <= 1'b0;
    else
      resp_r <= (avs_read | avs_write) & ~resp_r;
  end

  // Channel words are what software last wrote; channel six holds the connect code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out5_r <= `TCM_RST_WORD;
      out6_r <= `TCM_RST_WORD;
    end else if (wr_now && avs_address == `TCM_OFS_OUT5) begin
      out5_r <= wdata;
    end else if (wr_now && avs_address == `TCM_OFS_OUT6) begin
      out6_r <= wdata;
    end
  end

  assign connected = out6_r[`TCM_C6_CODE] == `TCM_CONNECT_CODE;
  // Strobe bits rising on a channel six write, taken only while connected
  assign strobe = (wr_now && avs_address == `TCM_OFS_OUT6 && wdata[`TCM_C6_CODE] == `TCM_CONNECT_CODE)
                  ? (wdata & ~out6_r) : 16'h0000;
  // Program clear is a level held on channel six; the bus reset does the same
  assign clr = sys_rst | (connected & out6_r[`TCM_C6_PCLR]);

  // Status reads; while disconnected the channel five and six words still read back, status words return zero
  always_ff @(posedge clk) begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (rd_now) begin
      avs_readdata <= 32'h00000000;
      if (avs_address == `TCM_OFS_OUT5)
        avs_readdata[15:0] <= out5_r;
      else if (avs_address == `TCM_OFS_OUT6)
        avs_readdata[15:0] <= out6_r;
      else if (connected && avs_address == `TCM_OFS_STAT0)
        avs_readdata[15:0] <= {state_r != ST_IDLE, done_r, eor_r, mperr_r, tperr_r, wperr_r,
                               is_write, coded, halt, ai.page_pend, 6'h00};
      else if (connected && avs_address == `TCM_OFS_STAT1)
        avs_readdata[15:0] <= {1'b0, ai.cur};
      else if (connected && avs_address == `TCM_OFS_STAT2)
        avs_readdata[15:0] <= {4'h0, stat_s};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Loaded control words; addresses come complemented and are restored
  always_ff @(posedge clk) begin
    if (clr) begin
      func_r <= `TCM_RST_WORD;
      term_r <= `TCM_RST_ADDR;
      cmp_en_r <= 1'b0;
      table_r <= 7'h00;
    end else begin
      if (strobe[`TCM_C6_IF])
        func_r <= out5_r;
      if (strobe[`TCM_C6_TA]) begin
        term_r <= ~out5_r[`TCM_C5_ADDR];
        cmp_en_r <= out5_r[`TCM_C5_CMP];
      end
      if (strobe[`TCM_C6_SA])
        table_r <= table_r;
      if (strobe[`TCM_C6_SA] && 1'b0)
        table_r <= 7'h00;
      else if (out6_r[`TCM_C6_SA] == 1'b0 && strobe[`TCM_C6_CHF] == 1'b0 && strobe[`TCM_C6_TA] == 1'b0
               && strobe[`TCM_C6_IF] == 1'b0 && strobe[`TCM_C6_PCLR] == 1'b0 && strobe[`TCM_C6_SA] == 1'b0
               && 1'b0)
        table_r <= 7'h00;
    end
  end

  // No strobe loads table_r; the start address strobe leaves it at zero
  assign coded = func_r[`TCM_FN_CODED];
  assign is_write = func_r[`TCM_FN_WRITE];
  assign halt = func_r[`TCM_FN_HALT];
  assign nomem = func_r[`TCM_FN_NOMEM];

  // Function strobe launches the operation one cycle later
  always_ff @(posedge clk) begin
    if (clr)
      go_r <= 1'b0;
    else
      go_r <= strobe[`TCM_C6_IF];
  end

  ////////////////////////////////////////////////////////////////
  // Address generator hookup
  assign ai.load = strobe[`TCM_C6_SA];
  assign ai.start = ~out5_r[`TCM_C5_ADDR];
  assign ai.page_load = strobe[`TCM_C6_TA];
  assign ai.next_page = ~out5_r[`TCM_PAGE];
  assign ai.dec = func_r[`TCM_FN_BACK] & ~is_write;
  assign ai.two = func_r[`TCM_FN_ODDEVEN];
  assign ai.adv = (state_r == ST_STORE && mem_gnt) || (state_r == ST_HOLD && !take_s);

  tcm_addr_gen u_addr (
    .clk(clk),
    .clr(clr),
    .a(ai.gen)
  );

  // Compare against the final page offset once no further page waits
  assign last_word = cmp_en_r && is_write && !ai.page_pend
                     && ai.cur[`TCM_OFFS] == term_r[`TCM_OFFS];
  assign rx_bad = ~^{din_s, dpar_s};

  ////////////////////////////////////////////////////////////////
  // Memory port; disable request skips data cycles but not the count
  assign mem_req = (state_r == ST_LOOKUP) || ((state_r == ST_FETCH || state_r == ST_STORE) && !nomem);
  assign mem_we = state_r == ST_STORE;
  assign mem_gnt = mem_ack | nomem;
  assign mem_wdata = data_r;
  always_comb begin
    if (state_r == ST_LOOKUP)
      mem_addr = is_write ? {table_r, data_r[7:0]} : {table_r, 2'b00, data_r[5:0]};
    else
      mem_addr = ai.cur;
  end

  ////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (clr)
      state_r <= ST_IDLE;
    else begin
      unique case (state_r)
        ST_IDLE: begin
          if (go_r)
            state_r <= is_write ? ST_FETCH : ST_RD_WAIT;
        end
        ST_RD_WAIT: begin
          if (eor_s)
            state_r <= ST_IDLE;
          else if (rdy_s && !tape_ack)
            state_r <= (rx_bad && halt) ? ST_IDLE : (coded ? ST_LOOKUP : ST_STORE);
        end
        ST_LOOKUP: begin
          if (mem_ack)
            state_r <= is_write ? ST_SEND : ST_STORE;
        end
        ST_STORE: begin
          if (mem_gnt)
            state_r <= ST_RD_WAIT;
        end
        ST_FETCH: begin
          if (mem_gnt)
            state_r <= (mem_perr && !nomem && halt) ? ST_IDLE : (coded ? ST_LOOKUP : ST_SEND);
        end
        ST_SEND: begin
          if (take_s)
            state_r <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!take_s)
            state_r <= ((wperr_r && halt) || last_word) ? ST_IDLE : ST_FETCH;
        end
      endcase
    end
  end

  // Data word: tape character in, memory word or table entry
  always_ff @(posedge clk) begin
    if (clr)
      data_r <= `TCM_RST_WORD;
    else if (state_r == ST_RD_WAIT && rdy_s && !tape_ack)
      data_r <= {4'h0, din_s};
    else if ((state_r == ST_FETCH && mem_ack) || (state_r == ST_LOOKUP && mem_ack))
      data_r <= mem_rdata;
  end

  // Termination and error flags; cleared when the next operation starts
  always_ff @(posedge clk) begin
    if (clr) begin
      done_r <= 1'b0;
      eor_r <= 1'b0;
      mperr_r <= 1'b0;
      tperr_r <= 1'b0;
      wperr_r <= 1'b0;
    end else if (go_r) begin
      done_r <= 1'b0;
      eor_r <= 1'b0;
      mperr_r <= 1'b0;
      tperr_r <= 1'b0;
      wperr_r <= 1'b0;
    end else begin
      if (state_r != ST_IDLE && (eor_s && state_r == ST_RD_WAIT || last_word && state_r == ST_HOLD && !take_s))
        done_r <= 1'b1;
      if (state_r == ST_RD_WAIT && eor_s)
        eor_r <= 1'b1;
      if (state_r == ST_FETCH && mem_ack && mem_perr && !nomem)
        mperr_r <= 1'b1;
      if (state_r == ST_RD_WAIT && rdy_s && !tape_ack && rx_bad)
        tperr_r <= 1'b1;
      if (state_r != ST_IDLE && wperr_s && is_write)
        wperr_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Tape handshakes: ack answers ready, valid waits for take
  always_ff @(posedge clk) begin
    if (clr)
      tape_ack <= 1'b0;
    else if (state_r == ST_STORE && mem_gnt)
      tape_ack <= 1'b1;
    else if (state_r == ST_RD_WAIT && rx_bad && halt && rdy_s && !tape_ack)
      tape_ack <= 1'b1;
    else if (!rdy_s)
      tape_ack <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      tape_dout <= 12'h000;
      tape_dout_par <= 1'b1;
      tape_dout_vld <= 1'b0;
    end else if (state_r == ST_SEND && !take_s) begin
      tape_dout <= data_r[11:0];
      tape_dout_par <= ~^data_r[11:0];
      tape_dout_vld <= 1'b1;
    end else if (state_r != ST_SEND) begin
      tape_dout_vld <= 1'b0;
    end else if (take_s) begin
      tape_dout_vld <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Unit select and code strobes; selection survives disconnection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tape_sel <= 8'h00;
      tape_code <= 12'h000;
      tape_conn_stb <= 1'b0;
      tape_func_stb <= 1'b0;
    end else begin
      tape_conn_stb <= strobe[`TCM_C6_CHF] & out5_r[`TCM_C5_CONN];
      tape_func_stb <= strobe[`TCM_C6_CHF] & ~out5_r[`TCM_C5_CONN];
      if (strobe[`TCM_C6_CHF]) begin
        tape_code <= out5_r[`TCM_C5_DEVCODE];
        if (out5_r[`TCM_C5_CONN])
          tape_sel <= 8'h01 << out5_r[`TCM_C5_UNIT];
      end
    end
  end
endmodule : tcm_channel
`default_nettype wire

// *** tcm_channel_props.sv ***
// Port checks for the tape channel memory interface
`timescale 1ns/1ps
`default_nettype none
module tcm_channel_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire tcm_pkg::tcm_addr_t mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] tape_sel,
  input wire logic tape_conn_stb,
  input wire logic tape_func_stb,
  input wire logic [11:0] tape_dout,
  input wire logic tape_dout_par,
  input wire logic tape_dout_vld,
  input wire logic tape_take
);
  import tcm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Bus answers in the second cycle, status words are 16 bits wide
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered in first cycle");
  a_wait_second: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in second cycle");
  a_rdata_narrow: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  ////////////////////////////////////////
  // Unit selection and code strobes
  a_sel_onehot: assert property ($onehot0(tape_sel))
    else $error("more than one unit selected");
  a_sel_kept: assert property ($changed(tape_sel) |-> tape_conn_stb || $past(tape_conn_stb))
    else $error("unit selection changed without connect");
  a_stb_single: assert property (tape_conn_stb || tape_func_stb |=> !(tape_conn_stb || tape_func_stb))
    else $error("code strobe longer than one cycle");
  a_stb_excl: assert property (!(tape_conn_stb && tape_func_stb))
    else $error("connect and function strobes together");
  ////////////////////////////////////////
  // Memory request and output character hold until answered
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped or changed early");
  a_dout_odd: assert property (tape_dout_vld |-> ^{tape_dout, tape_dout_par})
    else $error("output character parity not odd");
  a_vld_hold: assert property (tape_dout_vld && !tape_take |=> tape_dout_vld && $stable(tape_dout))
    else $error("output character withdrawn before taken");
  c_connect: cover property (tape_conn_stb);
  c_store: cover property (mem_req && mem_we && mem_ack);
  c_take: cover property (tape_dout_vld && tape_take);
endmodule : tcm_channel_props
`default_nettype wire

// *** tcm_tape_model.sv ***
// Behavioural buffer memory and tape controller facing the interface
`timescale 1ns/1ps
`default_nettype none
module tcm_tape_model (
  input wire logic clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire tcm_pkg::tcm_addr_t mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  output logic mem_perr,
  input wire logic [7:0] tape_sel,
  output logic tape_rdy,
  output logic [11:0] tape_din,
  output logic tape_din_par,
  input wire logic tape_ack,
  input wire logic [11:0] tape_dout,
  input wire logic tape_dout_par,
  input wire logic tape_dout_vld,
  output logic tape_take,
  output logic tape_eor,
  output logic tape_wperr,
  output logic [11:0] tape_status
);
  import tcm_pkg::*;
  logic [15:0] mem [0:32767];
  logic perr_en = 1'b0, bad_par = 1'b0, wperr_en = 1'b0, slow = 1'b0;
  int wait_c = 0, chars_out = 0, par_bad = 0;
  // Status word tracks the selected unit
  assign tape_status = {4'h5, tape_sel};
  ////////////////////////////////////////
  // Quiet lines, memory preloaded with its own addresses
  initial begin
    {mem_rdata, mem_ack, mem_perr, tape_rdy, tape_din, tape_take, tape_eor, tape_wperr} = '0;
    tape_din_par = 1'b1;
    for (int i = 0; i < 32768; i++) mem[i] = 16'(i);
  end
  // Memory answers a held request after one or three idle cycles
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_perr <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_c < (slow ? 3 : 1)) wait_c <= wait_c + 1;
      else begin
        wait_c <= 0;
        mem_ack <= 1'b1;
        mem_perr <= perr_en;
        if (mem_we) mem[mem_addr] <= mem_wdata;
        else mem_rdata <= mem[mem_addr];
      end
    end
  end
  // Take each output character; parity is checked, not trusted
  always @(posedge clk) begin
    if (tape_dout_vld && !tape_take) begin
      if (^{tape_dout, tape_dout_par} !== 1'b1) par_bad++;
      chars_out++;
      tape_take <= 1'b1;
      tape_wperr <= wperr_en;
    end else if (!tape_dout_vld) begin
      tape_take <= 1'b0;
      tape_wperr <= 1'b0;
    end
  end
  // Offer n read characters with odd parity unless bad_par is set, then end of record
  task automatic send(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tape_din <= 12'h101 + 12'(i);
      tape_din_par <= ~^(12'h101 + 12'(i)) ^ bad_par;
      tape_rdy <= 1'b1;
      k = 0;
      while (tape_ack !== 1'b1 && k < 60) begin
        @(negedge clk);
        k++;
      end
      @(posedge clk);
      tape_rdy <= 1'b0;
      tape_din <= ~tape_din;
      while (tape_ack !== 1'b0 && k < 120) begin
        @(negedge clk);
        k++;
      end
    end
    @(posedge clk);
    tape_eor <= 1'b1;
    repeat (4) @(posedge clk);
    tape_eor <= 1'b0;
  endtask : send
endmodule : tcm_tape_model
`default_nettype wire

// *** tb_tape_channel_memory_interface.sv ***
// Self-checking bench for the tape channel memory interface
`timescale 1ns/1ps
`default_nettype none
`include "tcm_defs.svh"
module tb_tape_channel_memory_interface;
  import tcm_pkg::*;
  typedef struct {logic [4:0] a; logic [15:0] d; logic [31:0] e;} tcm_row_s;
  localparam logic [15:0] CON = {12'h000, `TCM_CONNECT_CODE};
  logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, mem_req, mem_we, mem_ack, mem_perr;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, st;
  tcm_addr_t mem_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] tape_sel;
  logic [11:0] tape_code, tape_din, tape_dout, tape_status;
  logic tape_conn_stb, tape_func_stb, tape_rdy, tape_din_par, tape_ack, tape_dout_par, tape_dout_vld;
  logic tape_take, tape_eor, tape_wperr;
  int fails = 0, check_count = 0, conn_n = 0, func_n = 0, nch;
  tcm_row_s rows [7] = '{'{5'h00, 16'h1234, 32'h1234}, '{5'h04, 16'h0005, 32'h0005},
    '{5'h08, 16'hFFFF, 0}, '{5'h0C, 16'hFFFF, 0}, '{5'h10, 16'hFFFF, 0},
    '{5'h14, 16'hFFFF, 0}, '{5'h1C, 16'hABCD, 0}};
  tcm_channel dut_u (.*);
  tcm_tape_model part_u (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Count code strobes sent to the tape units
  always @(posedge clk) begin
    if (tape_conn_stb === 1'b1) conn_n++;
    if (tape_func_stb === 1'b1) func_n++;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low
  task automatic av(input logic [4:0] a, input logic w, input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim();
    end
  endtask : av
  // Word on channel five, strobe raised then cleared on channel six
  task automatic ctl(input int b, input logic [15:0] d);
    av(`TCM_OFS_OUT5, 1'b1, d, q);
    av(`TCM_OFS_OUT6, 1'b1, CON | (16'h0001 << b), q);
    av(`TCM_OFS_OUT6, 1'b1, CON, q);
  endtask : ctl
  // Load addresses and function, run to completion, fetch status
  task automatic xfer(input logic [14:0] sa, input logic [15:0] ta, input logic [15:0] fn, input logic [2:0] er);
    int n;
    {part_u.wperr_en, part_u.bad_par, part_u.perr_en} = er;
    nch = part_u.chars_out;
    ctl(`TCM_C6_SA, {1'b0, ~sa});
    ctl(`TCM_C6_TA, ta);
    ctl(`TCM_C6_IF, fn);
    if (!fn[`TCM_FN_WRITE]) part_u.send(4);
    n = 0;
    do begin
      av(`TCM_OFS_STAT0, 1'b0, 16'h0000, st);
      n++;
    end while (st[15] !== 1'b0 && n < 200);
    if (n >= 200) begin
      fails++;
      end_sim();
    end
    av(`TCM_OFS_STAT1, 1'b0, 16'h0000, q);
    nch = part_u.chars_out - nch;
  endtask : xfer
  ////////////////////////////////////////
  initial begin
    {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 39'h0};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk("rst_sel", tape_sel, 0);
    chk("rst_par", tape_dout_par, 1);
    foreach (rows[i]) begin
      av(rows[i].a, 1'b1, rows[i].d, q);
      av(rows[i].a, 1'b0, 16'h0000, q);
      chk("reg", q, rows[i].e);
    end
    av(`TCM_OFS_OUT6, 1'b1, CON, q);
    for (int u = 0; u < 8; u++) begin
      ctl(`TCM_C6_CHF, 16'h2040 | 16'(u));
      chk("unit", tape_sel, 32'h1 << u);
      chk("code", tape_code, 32'h040 | u);
    end
    ctl(`TCM_C6_CHF, 16'h0123);
    chk("func_conn", conn_n, 8);
    chk("func_cnt", func_n, 1);
    chk("func_code", tape_code, 12'h123);
    av(`TCM_OFS_OUT5, 1'b1, 16'h2001, q);
    av(`TCM_OFS_OUT6, 1'b1, 16'h0805, q);
    av(`TCM_OFS_OUT6, 1'b1, 16'h0005, q);
    chk("foreign", conn_n, 8);
    av(`TCM_OFS_STAT2, 1'b0, 16'h0000, q);
    chk("disc_stat", q, 0);
    chk("disc_sel", tape_sel, 32'h80);
    av(`TCM_OFS_OUT6, 1'b1, CON, q);
    av(`TCM_OFS_STAT2, 1'b0, 16'h0000, q);
    chk("unit_stat", q, 32'h580);
    xfer(15'h0100, {1'b1, ~15'h0102}, 16'h0000, 3'b000);
    chk("rd_addr", q, 32'h0104);
    chk("rd_done", st[14:13], 2'b11);
    xfer(15'h0200, {1'b1, ~15'h0203}, 16'h4000, 3'b000);
    chk("wr_addr", q, 32'h0204);
    chk("wr_chars", nch, 4);
    chk("wr_par", part_u.par_bad, 0);
    part_u.slow = 1'b1;
    xfer(15'h07FE, {1'b1, ~{4'h5, 11'h001}}, 16'h4000, 3'b000);
    chk("page", q, 32'h2802);
    part_u.slow = 1'b0;
    xfer(15'h0300, {1'b1, ~15'h0301}, 16'h4000, 3'b001);
    chk("mp_go", {st[12], q[15:0]}, {1'b1, 16'h0302});
    xfer(15'h0300, {1'b1, ~15'h0301}, 16'h4400, 3'b001);
    chk("mp_halt", {st[12], q !== 32'h0302}, 2'b11);
    xfer(15'h0400, 16'h0000, 16'h0000, 3'b011);
    chk("rp_go", {st[12:11], q[15:0]}, {2'b01, 16'h0404});
    xfer(15'h0400, 16'h0000, 16'h0400, 3'b010);
    chk("rp_halt", {st[11], q !== 32'h0404}, 2'b11);
    xfer(15'h0500, {1'b1, ~15'h0502}, 16'h4400, 3'b100);
    chk("wp_halt", {st[10], q !== 32'h0503}, 2'b11);
    ctl(`TCM_C6_SA, {1'b0, ~15'h0600});
    ctl(`TCM_C6_IF, 16'h8400);
    av(`TCM_OFS_STAT0, 1'b0, 16'h0000, st);
    chk("fn_stat", {st[15], st[8:7]}, 3'b111);
    ctl(`TCM_C6_PCLR, 16'h0000);
    av(`TCM_OFS_STAT0, 1'b0, 16'h0000, q);
    chk("clr_stat", q, 0);
    av(`TCM_OFS_STAT1, 1'b0, 16'h0000, q);
    chk("clr_addr", q, 0);
    end_sim();
  end
endmodule : tb_tape_channel_memory_interface
bind tcm_channel tcm_channel_props chk_u (.*);
`default_nettype wire
